/* File: hw/tlm_pkg.sv */
package tlm_pkg;

    // Register offsets on the host register port.
    localparam logic [7:0] ADDR_CONFIG_ONE = 8'h01;
    localparam logic [7:0] ADDR_MASK_ONE = 8'h08;
    localparam logic [7:0] ADDR_MASK_TWO = 8'h09;
    localparam logic [7:0] ADDR_MASK_THREE = 8'h0a;
    localparam logic [7:0] ADDR_LOCAL_HIGH_LIMIT = 8'h0b;
    localparam logic [7:0] ADDR_LOCAL_LOW_LIMIT = 8'h0c;
    localparam logic [7:0] ADDR_LOCAL_OVERTEMP_LIMIT = 8'h0d;
    localparam logic [7:0] ADDR_REMOTE_HIGH_LIMIT = 8'h0e;
    localparam logic [7:0] ADDR_REMOTE_LOW_LIMIT = 8'h0f;
    localparam logic [7:0] ADDR_REMOTE_OVERTEMP_LIMIT = 8'h10;
    localparam logic [7:0] ADDR_LOCAL_OFFSET = 8'h16;
    localparam logic [7:0] ADDR_REMOTE_OFFSET = 8'h17;
    localparam logic [7:0] ADDR_OVERTEMP_ONTIME_PCT_LIMIT = 8'h19;
    localparam logic [7:0] ADDR_LOCAL_VALUE_LOW = 8'h40;
    localparam logic [7:0] ADDR_LOCAL_VALUE_HIGH = 8'h41;
    localparam logic [7:0] ADDR_REMOTE_VALUE_LOW = 8'h42;
    localparam logic [7:0] ADDR_REMOTE_VALUE_HIGH = 8'h43;
    localparam logic [7:0] ADDR_STATUS_ONE = 8'h4f;
    localparam logic [7:0] ADDR_STATUS_TWO = 8'h50;
    localparam logic [7:0] ADDR_STATUS_THREE = 8'h51;

    // Reset values.
    localparam logic [7:0] RST_CONFIG_ONE = 8'h01;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] RST_HIGH_LIMIT = 8'h8b;
    localparam logic [7:0] RST_LOW_LIMIT = 8'h54;
    localparam logic [7:0] RST_OVERTEMP_LIMIT = 8'h95;
    localparam logic [7:0] RST_OFFSET = 8'h00;
    localparam logic [7:0] RST_ONTIME_PCT_LIMIT = 8'hff;
    localparam logic [12:0] RST_VALUE = 13'h0000;

    // Configuration register one field positions.
    localparam int CFG_MONITOR_BIT = 0;
    localparam int CFG_ALERT_MODE_BIT = 3;

    // Value layout: 13 bits of 0.03125 degree, top 8 bits are whole degrees.
    localparam int VALUE_W = 13;
    localparam int VALUE_FRAC_W = 5;
    // One offset step of 0.125 degree is four value steps.
    localparam int OFFSET_SHIFT = 2;

    // Conversion times in ms, clock in Hz, derived cycle counts.
    localparam int LOCAL_CONV_MS = 11;
    localparam int REMOTE_CONV_MS = 32;
    localparam int CLK_HZ = 40000000;
    localparam int LOCAL_CONV_CYC = LOCAL_CONV_MS * (CLK_HZ / 1000);
    localparam int REMOTE_CONV_CYC = REMOTE_CONV_MS * (CLK_HZ / 1000);
    localparam int TIMER_W = 24;

    // Host register access request.
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } tlm_req_t;

    // Live out-of-limit conditions, one per sticky flag.
    typedef struct packed {
        logic local_high_flag;
        logic local_low_flag;
        logic remote_high_flag;
        logic remote_low_flag;
        logic remote_diode_fault_flag;
        logic local_overtemp_flag;
        logic remote_overtemp_flag;
        logic ontime_flag;
        logic overtemp_asserted_flag;
        logic overtemp_pin_state_flag;
        logic fan_stall_flag;
        logic fan_alarm_flag;
    } tlm_flags_t;

endpackage : tlm_pkg

/* File: hw/tlm_monitor.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Per-channel offset added before storing value.
// - Offset is signed 0.125 degree step, resets zero.
// - Six 8-bit high, low, overtemp limit registers.
// - High limit flags when value >= limit.
// - Low limit flags when value < limit.
// - Round-robin conversions set matching status bits.
// - Standby bit 0 starts or stops monitoring.
// - Each finished conversion updates its value register.
// - Local takes 11 ms, remote 32 ms, repeat.
// - Fan measurement runs unsynchronised, concurrently.
// - Status 1 means out of limit, contiguous.
// - Sticky until in-limit and read, or ARA.
// - Status three bit 0 shows alert driven low.
// - Alert pin signals out-of-limit without polling.
// - Mask bits gate alert, status still sets.
// - Status one holds local/remote high/low, diode fault.
// - Status two holds overtemp, on-time, asserted bits.
// - Pin-state bit clears only when pin inactive.
// - Config bit 3 selects latched or comparator alert.
// - Value step 0.03125 degree, code 64 is zero.
module tlm_monitor
    import tlm_pkg::*;
#(
    parameter int LOCAL_CONV_CYCLES = LOCAL_CONV_CYC,
    parameter int REMOTE_CONV_CYCLES = REMOTE_CONV_CYC
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Host register port, served by the serial bus engine.
    input wire tlm_req_t reg_req,
    output logic [7:0] reg_rdata,
    // Alert response address transaction finished, one-cycle pulse.
    input wire logic ara_done,
    // Converter side: raw result of the channel being converted.
    input wire logic [12:0] adc_raw,
    output logic conv_remote,
    output logic conv_done,
    // Asynchronous level inputs from pins and the analog front end.
    input wire logic remote_diode_fault,
    input wire logic overtemp_pin_active,
    // Same-clock events from the overtemp timer and fan logic.
    input wire logic ontime_exceeded,
    input wire logic overtemp_asserted,
    input wire logic fan_stall,
    input wire logic fan_alarm,
    // Open-drain alert pin; enable is low while the pin is pulled low.
    output logic alert_out,
    output logic alert_oe_n
);

    // Sequencer states; idle means standby.
    typedef enum logic [1:0] {ST_IDLE, ST_LOCAL, ST_REMOTE} tlm_state_t;

    // Configuration, masks, limits and offsets.
    logic [7:0] config_one_q;
    logic [7:0] mask_one_q;
    logic [7:0] mask_two_q;
    logic [7:0] mask_three_q;
    logic [7:0] local_high_limit_q;
    logic [7:0] local_low_limit_q;
    logic [7:0] local_overtemp_limit_q;
    logic [7:0] remote_high_limit_q;
    logic [7:0] remote_low_limit_q;
    logic [7:0] remote_overtemp_limit_q;
    logic [7:0] local_offset_q;
    logic [7:0] remote_offset_q;
    logic [7:0] ontime_pct_limit_q;
    // Corrected values of each channel.
    logic [12:0] local_value_q;
    logic [12:0] remote_value_q;
    // Sequencer state and conversion timer.
    tlm_state_t state_q;
    logic [TIMER_W-1:0] timer_q;
    // Synchronisers for the asynchronous inputs.
    logic [1:0] diode_sync_q;
    logic [1:0] pin_sync_q;
    // Live limit results held between conversions.
    logic local_high_q, local_low_q, local_ot_q;
    logic remote_high_q, remote_low_q, remote_ot_q;
    // Sticky status flags and the alert drive.
    tlm_flags_t sticky_q;
    logic alert_drive_q;

    // Combinational helpers.
    tlm_flags_t live;
    tlm_flags_t clr;
    logic conv_end;
    logic [7:0] cur_offset;
    logic signed [14:0] corrected;
    logic [12:0] corrected_sat;
    logic [12:0] cur_high, cur_low, cur_ot;
    logic rd_one, rd_two, rd_three;
    logic [11:0] mask_vec;
    logic alert_want;

    // Writable registers, including the standby and alert mode bits.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            config_one_q <= RST_CONFIG_ONE;
            mask_one_q <= RST_MASK;
            mask_two_q <= RST_MASK;
            mask_three_q <= RST_MASK;
            local_high_limit_q <= RST_HIGH_LIMIT;
            local_low_limit_q <= RST_LOW_LIMIT;
            local_overtemp_limit_q <= RST_OVERTEMP_LIMIT;
            remote_high_limit_q <= RST_HIGH_LIMIT;
            remote_low_limit_q <= RST_LOW_LIMIT;
            remote_overtemp_limit_q <= RST_OVERTEMP_LIMIT;
            local_offset_q <= RST_OFFSET;
            remote_offset_q <= RST_OFFSET;
            ontime_pct_limit_q <= RST_ONTIME_PCT_LIMIT;
        end else if (reg_req.wr) begin
            // Writes to read-only or unmapped offsets are dropped.
            case (reg_req.addr)
                ADDR_CONFIG_ONE: config_one_q <= reg_req.wdata;
                ADDR_MASK_ONE: mask_one_q <= reg_req.wdata;
                ADDR_MASK_TWO: mask_two_q <= reg_req.wdata;
                ADDR_MASK_THREE: mask_three_q <= reg_req.wdata;
                ADDR_LOCAL_HIGH_LIMIT: local_high_limit_q <= reg_req.wdata;
                ADDR_LOCAL_LOW_LIMIT: local_low_limit_q <= reg_req.wdata;
                ADDR_LOCAL_OVERTEMP_LIMIT: begin
                    local_overtemp_limit_q <= reg_req.wdata;
                end
                ADDR_REMOTE_HIGH_LIMIT: remote_high_limit_q <= reg_req.wdata;
                ADDR_REMOTE_LOW_LIMIT: remote_low_limit_q <= reg_req.wdata;
                ADDR_REMOTE_OVERTEMP_LIMIT: begin
                    remote_overtemp_limit_q <= reg_req.wdata;
                end
                ADDR_LOCAL_OFFSET: local_offset_q <= reg_req.wdata;
                ADDR_REMOTE_OFFSET: remote_offset_q <= reg_req.wdata;
                ADDR_OVERTEMP_ONTIME_PCT_LIMIT: begin
                    ontime_pct_limit_q <= reg_req.wdata;
                end
                default: ;
            endcase
        end
    end

    // Round-robin sequencer; a conversion ends when its time elapses.
    // Clearing standby mid-conversion abandons it, so no stale result lands.
    assign conv_end = (state_q != ST_IDLE) && (timer_q == '0);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            timer_q <= '0;
        end else if (!config_one_q[CFG_MONITOR_BIT]) begin
            state_q <= ST_IDLE;
            timer_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // Power-up or a written 1 starts with local.
                    state_q <= ST_LOCAL;
                    timer_q <= TIMER_W'(LOCAL_CONV_CYCLES - 1);
                end
                ST_LOCAL: begin
                    if (conv_end) begin
                        state_q <= ST_REMOTE;
                        timer_q <= TIMER_W'(REMOTE_CONV_CYCLES - 1);
                    end else begin
                        timer_q <= timer_q - 1'b1;
                    end
                end
                ST_REMOTE: begin
                    if (conv_end) begin
                        state_q <= ST_LOCAL;
                        timer_q <= TIMER_W'(LOCAL_CONV_CYCLES - 1);
                    end else begin
                        timer_q <= timer_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    timer_q <= '0;
                end
            endcase
        end
    end

    // Converter strobes: channel select and end of conversion.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            conv_remote <= 1'b0;
            conv_done <= 1'b0;
        end else begin
            conv_remote <= (state_q == ST_REMOTE);
            conv_done <= conv_end;
        end
    end

    // Offset correction: signed offset scaled to value steps, then
    // saturated so a large offset cannot wrap a reading round.
    assign cur_offset = (state_q == ST_REMOTE) ? remote_offset_q
                                               : local_offset_q;
    assign corrected = $signed({2'b00, adc_raw})
        + ($signed({{5{cur_offset[7]}}, cur_offset, 2'b00}));
    always_comb begin
        if (corrected < 0) begin
            corrected_sat = '0;
        end else if (corrected > 15'sd8191) begin
            corrected_sat = '1;
        end else begin
            corrected_sat = corrected[12:0];
        end
    end

    // Value registers take each result as soon as it is done.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            local_value_q <= RST_VALUE;
            remote_value_q <= RST_VALUE;
        end else if (conv_end && state_q == ST_LOCAL) begin
            local_value_q <= corrected_sat;
        end else if (conv_end && state_q == ST_REMOTE) begin
            remote_value_q <= corrected_sat;
        end
    end

    // Limits are whole degrees with 64 as zero, so they align with the
    // top eight bits of the 0.03125 degree value.
    assign cur_high = (state_q == ST_REMOTE)
        ? {remote_high_limit_q, 5'h00} : {local_high_limit_q, 5'h00};
    assign cur_low = (state_q == ST_REMOTE)
        ? {remote_low_limit_q, 5'h00} : {local_low_limit_q, 5'h00};
    assign cur_ot = (state_q == ST_REMOTE)
        ? {remote_overtemp_limit_q, 5'h00} : {local_overtemp_limit_q, 5'h00};

    // Limit checks on the corrected result, held until the next pass.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            local_high_q <= 1'b0;
            local_low_q <= 1'b0;
            local_ot_q <= 1'b0;
            remote_high_q <= 1'b0;
            remote_low_q <= 1'b0;
            remote_ot_q <= 1'b0;
        end else if (conv_end && state_q == ST_LOCAL) begin
            local_high_q <= (corrected_sat >= cur_high);
            local_low_q <= (corrected_sat < cur_low);
            local_ot_q <= (corrected_sat >= cur_ot);
        end else if (conv_end && state_q == ST_REMOTE) begin
            remote_high_q <= (corrected_sat >= cur_high);
            remote_low_q <= (corrected_sat < cur_low);
            remote_ot_q <= (corrected_sat >= cur_ot);
        end
    end

    // Two-stage synchronisers; only the second stage is read.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            diode_sync_q <= 2'b00;
            pin_sync_q <= 2'b00;
        end else begin
            diode_sync_q <= {diode_sync_q[0], remote_diode_fault};
            pin_sync_q <= {pin_sync_q[0], overtemp_pin_active};
        end
    end

    // Live conditions; fan events arrive on their own, with no tie to
    // the temperature sequence.
    assign live = '{local_high_q, local_low_q, remote_high_q, remote_low_q,
        diode_sync_q[1], local_ot_q, remote_ot_q, ontime_exceeded,
        overtemp_asserted, pin_sync_q[1],
        fan_stall, fan_alarm};

    // Status reads; each read clears only flags whose condition is gone.
    assign rd_one = reg_req.rd && (reg_req.addr == ADDR_STATUS_ONE);
    assign rd_two = reg_req.rd && (reg_req.addr == ADDR_STATUS_TWO);
    assign rd_three = reg_req.rd && (reg_req.addr == ADDR_STATUS_THREE);

    assign clr = '{rd_one, rd_one, rd_one, rd_one, rd_one, rd_two, rd_two,
        rd_two, rd_two, rd_two, rd_three, rd_three};

    // Sticky flags: a live condition always wins over any clear, so an
    // event landing on the clearing read is kept. The alert response
    // clears every flag whose condition is gone; a lasting fault stays set.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sticky_q <= '0;
        end else begin
            sticky_q <= live
                | (sticky_q & ~((clr & ~live)
                | {12{ara_done}}));
        end
    end

    // Mask bits in the order of the flag struct.
    assign mask_vec = {mask_one_q[7:3], 2'b00, mask_two_q[4:2],
                       mask_three_q[7:6]};

    // Latched mode follows the unmasked sticky flags; comparator mode
    // follows live conditions and ignores the pin-state flag.
    always_comb begin
        if (config_one_q[CFG_ALERT_MODE_BIT]) begin
            alert_want = |(live & ~mask_vec
                & ~12'h004);
        end else begin
            alert_want = |(sticky_q & ~mask_vec);
        end
    end

    // Alert drive is registered; the pin is only ever pulled low.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            alert_drive_q <= 1'b0;
        end else begin
            alert_drive_q <= alert_want;
        end
    end
    assign alert_out = 1'b0;
    assign alert_oe_n = ~alert_drive_q;

    // Read data, one cycle after the read strobe; unmapped reads zero.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                ADDR_CONFIG_ONE: reg_rdata <= config_one_q;
                ADDR_MASK_ONE: reg_rdata <= mask_one_q;
                ADDR_MASK_TWO: reg_rdata <= mask_two_q;
                ADDR_MASK_THREE: reg_rdata <= mask_three_q;
                ADDR_LOCAL_HIGH_LIMIT: reg_rdata <= local_high_limit_q;
                ADDR_LOCAL_LOW_LIMIT: reg_rdata <= local_low_limit_q;
                ADDR_LOCAL_OVERTEMP_LIMIT: begin
                    reg_rdata <= local_overtemp_limit_q;
                end
                ADDR_REMOTE_HIGH_LIMIT: reg_rdata <= remote_high_limit_q;
                ADDR_REMOTE_LOW_LIMIT: reg_rdata <= remote_low_limit_q;
                ADDR_REMOTE_OVERTEMP_LIMIT: begin
                    reg_rdata <= remote_overtemp_limit_q;
                end
                ADDR_LOCAL_OFFSET: reg_rdata <= local_offset_q;
                ADDR_REMOTE_OFFSET: reg_rdata <= remote_offset_q;
                ADDR_OVERTEMP_ONTIME_PCT_LIMIT: begin
                    reg_rdata <= ontime_pct_limit_q;
                end
                ADDR_LOCAL_VALUE_LOW: reg_rdata <= {local_value_q[4:0], 3'h0};
                ADDR_LOCAL_VALUE_HIGH: reg_rdata <= local_value_q[12:5];
                ADDR_REMOTE_VALUE_LOW: begin
                    reg_rdata <= {remote_value_q[4:0], 3'b000};
                end
                ADDR_REMOTE_VALUE_HIGH: reg_rdata <= remote_value_q[12:5];
                // The flag struct runs in status order: five status one
                // bits, five status two bits, then the two fan bits.
                ADDR_STATUS_ONE: reg_rdata <= {sticky_q[11:7], 3'h0};
                ADDR_STATUS_TWO: begin
                    reg_rdata <= {sticky_q[6:5], 1'h0, sticky_q[4:2],
                                  2'h0};
                end
                ADDR_STATUS_THREE: begin
                    reg_rdata <= {sticky_q[1:0], 5'h0, alert_drive_q};
                end
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule : tlm_monitor

/* File: bench/tlm_monitor_asserts.sv */
`timescale 1ns/1ps
// Port-level checks on the monitor; it sees only the monitor's ports.
module tlm_monitor_asserts
    import tlm_pkg::*;
#(
    parameter int LOCAL_CONV_CYCLES = 8,
    parameter int REMOTE_CONV_CYCLES = 12
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Register port and conversion strobe.
    input wire tlm_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic conv_done,
    // Event inputs and alert pin.
    input wire logic remote_diode_fault,
    input wire logic ontime_exceeded,
    input wire logic fan_stall,
    input wire logic alert_out,
    input wire logic alert_oe_n
);
    // Standby may restart a phase, so only the shortest spacing is fixed.
    localparam int MIN_GAP = (LOCAL_CONV_CYCLES < REMOTE_CONV_CYCLES) ?
        LOCAL_CONV_CYCLES : REMOTE_CONV_CYCLES;
    int gap_q;
    // Cycles since the last completion pulse, saturating.
    always_ff @(posedge clk) begin
        if (!nrst || conv_done) begin
            gap_q <= 1;
        end else if (gap_q < 100000) begin
            gap_q <= gap_q + 1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // A read strobe to one register offset.
    sequence s_read(logic [7:0] a);
        reg_req.rd && reg_req.addr == a;
    endsequence
    // The diode fault has been held long enough to pass the synchroniser.
    sequence s_fault_held;
        remote_diode_fault [*4];
    endsequence
    AST_ALERT_DRIVE: assert property (alert_out == 1'b0)
        else $error("alert drive value not low");
    AST_CONV_GAP: assert property (conv_done |-> gap_q >= MIN_GAP)
        else $error("conversions completed too close together");
    AST_READ_HOLD: assert property (!reg_req.rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    AST_UNMAPPED: assert property (s_read(8'h30) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_ALERT_BIT: assert property (s_read(ADDR_STATUS_THREE) ##1
        $stable(alert_oe_n) |-> reg_rdata[0] == !alert_oe_n)
        else $error("alert status bit disagrees with pin");
    AST_DIODE: assert property (s_fault_held ##0
        s_read(ADDR_STATUS_ONE) |=> reg_rdata[3])
        else $error("diode fault not reported");
    AST_FAN_STICKY: assert property (fan_stall ##2
        s_read(ADDR_STATUS_THREE) |=> reg_rdata[7])
        else $error("fan stall flag lost");
    AST_ONTIME: assert property (ontime_exceeded ##2
        s_read(ADDR_STATUS_TWO) |=> reg_rdata[4])
        else $error("on-time flag lost");
endmodule : tlm_monitor_asserts

bind tlm_monitor tlm_monitor_asserts #(
    .LOCAL_CONV_CYCLES(LOCAL_CONV_CYCLES),
    .REMOTE_CONV_CYCLES(REMOTE_CONV_CYCLES)
) i_asserts (
    .clk(clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .conv_done(conv_done), .remote_diode_fault(remote_diode_fault),
    .ontime_exceeded(ontime_exceeded), .fan_stall(fan_stall),
    .alert_out(alert_out), .alert_oe_n(alert_oe_n)
);

/* File: bench/tlm_host_model.sv */
`timescale 1ns/1ps
// Host side of the register port: one strobe held over one edge, then
// idle with scrambled address and data so stale values are never reused.
module tlm_host_model
    import tlm_pkg::*;
(
    // Clock.
    input wire logic clk,
    // Register port.
    output tlm_req_t reg_req,
    input wire logic [7:0] reg_rdata
);
    initial reg_req = '0;
    // One access; the request stands until its sampling edge.
    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] v);
        @(posedge clk);
        reg_req <= '{a, w, !w, v};
        @(posedge clk);
        reg_req <= '{~a, 1'b0, 1'b0, ~v};
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        xfer(a, 1'b1, v);
    endtask : wr
    // Status polling; data is taken once the sampling edge has landed.
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        xfer(a, 1'b0, ~a);
        #1 v = reg_rdata;
    endtask : rd
endmodule : tlm_host_model

/* File: bench/tb_temp_limit_status_monitor.sv */
`timescale 1ns/1ps
// Self-checking bench; the host model owns the register port.
module tb_temp_limit_status_monitor;
    logic clk = 1'b0, nrst = 1'b0, ara_done = 1'b0, diode = 1'b0, pin = 1'b0;
    logic ontime = 1'b0, ota = 1'b0, stall = 1'b0, alarm = 1'b0;
    logic conv_remote, conv_done, alert_out, alert_oe_n;
    logic [12:0] adc_raw = 13'h0a80, loc_t = 13'h0a80;
    logic [7:0] rdata, d;
    tlm_pkg::tlm_req_t reg_req;
    int failures = 0, num_checks = 0;
    // Small counts make one round robin twenty cycles long.
    tlm_monitor #(.LOCAL_CONV_CYCLES(8), .REMOTE_CONV_CYCLES(12)) i_dut (
        .clk(clk), .nrst(nrst), .reg_req(reg_req), .reg_rdata(rdata),
        .ara_done(ara_done), .adc_raw(adc_raw), .conv_remote(conv_remote),
        .conv_done(conv_done), .remote_diode_fault(diode),
        .overtemp_pin_active(pin), .ontime_exceeded(ontime),
        .overtemp_asserted(ota), .fan_stall(stall), .fan_alarm(alarm),
        .alert_out(alert_out), .alert_oe_n(alert_oe_n));
    tlm_host_model i_host (.clk(clk), .reg_req(reg_req), .reg_rdata(rdata));
    initial forever #12.5 clk = ~clk;
    // Converter stand-in: remote sits at 20 C, local follows loc_t.
    always @(posedge clk) adc_raw <= conv_remote ? 13'h0a80 : loc_t;
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_pin(input logic exp);
        chk_reg({7'h00, alert_oe_n}, {7'h00, exp});
    endtask : chk_pin
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        i_host.rd(a, d);
        chk_reg(d, e);
    endtask : rdx
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // Cycles up to the next completion pulse, bounded.
    task automatic gap(output int g);
        g = 0;
        do begin
            cyc(1);
            g++;
        end while (conv_done !== 1'b1 && g < 100);
    endtask : gap
    task automatic t_reset();
        logic [7:0] a[13] = '{8'h01, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c,
            8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h16, 8'h17, 8'h19};
        logic [7:0] e[13] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h8b, 8'h54,
            8'h95, 8'h8b, 8'h54, 8'h95, 8'h00, 8'h00, 8'hff};
        foreach (a[i]) rdx(a[i], e[i]);
        i_host.wr(8'h30, 8'h5a);
        rdx(8'h30, 8'h00);
        $display("reset test done");
    endtask : t_reset
    // Offsets shift values and limit decisions; flags stick until read.
    task automatic t_limits();
        loc_t <= 13'h0a83;
        i_host.wr(8'h16, 8'h08);
        i_host.wr(8'h17, 8'hf8);
        i_host.wr(8'h0b, 8'h55);
        i_host.wr(8'h0e, 8'h53);
        i_host.wr(8'h0f, 8'h53);
        cyc(45);
        rdx(8'h40, 8'h18);
        rdx(8'h41, 8'h55);
        rdx(8'h43, 8'h53);
        i_host.rd(8'h4f, d);
        rdx(8'h4f, 8'ha0);
        i_host.wr(8'h0f, 8'h54);
        cyc(45);
        rdx(8'h4f, 8'hb0);
        i_host.wr(8'h0b, 8'h8b);
        i_host.wr(8'h0e, 8'h8b);
        i_host.wr(8'h0f, 8'h00);
        cyc(45);
        rdx(8'h4f, 8'hb0);
        rdx(8'h4f, 8'h00);
        $display("limit test done");
    endtask : t_limits
    task automatic t_alert();
        diode <= 1'b1;
        cyc(5);
        chk_pin(1'b0);
        rdx(8'h4f, 8'h08);
        diode <= 1'b0;
        cyc(4);
        rdx(8'h51, 8'h01);
        rdx(8'h4f, 8'h08);
        cyc(2);
        chk_pin(1'b1);
        i_host.wr(8'h0a, 8'h80);
        stall <= 1'b1;
        cyc(1);
        stall <= 1'b0;
        rdx(8'h51, 8'h80);
        chk_pin(1'b1);
        i_host.wr(8'h01, 8'h09);
        alarm <= 1'b1;
        cyc(3);
        chk_pin(1'b0);
        alarm <= 1'b0;
        pin <= 1'b1;
        cyc(5);
        chk_pin(1'b1);
        rdx(8'h50, 8'h04);
        rdx(8'h50, 8'h04);
        pin <= 1'b0;
        cyc(4);
        i_host.rd(8'h50, d);
        rdx(8'h50, 8'h00);
        rdx(8'h51, 8'h40);
        i_host.wr(8'h01, 8'h01);
        $display("alert test done");
    endtask : t_alert
    task automatic t_ara();
        ontime <= 1'b1;
        ota <= 1'b1;
        cyc(1);
        ontime <= 1'b0;
        ota <= 1'b0;
        rdx(8'h50, 8'h18);
        ota <= 1'b1;
        cyc(1);
        ota <= 1'b0;
        cyc(3);
        chk_pin(1'b0);
        ara_done <= 1'b1;
        cyc(1);
        ara_done <= 1'b0;
        cyc(3);
        chk_pin(1'b1);
        rdx(8'h50, 8'h00);
        $display("ara test done");
    endtask : t_ara
    task automatic t_standby();
        int g;
        i_host.wr(8'h01, 8'h00);
        cyc(3);
        gap(g);
        chk_reg(8'(g), 8'h64);
        i_host.wr(8'h01, 8'h01);
        gap(g);
        gap(g);
        chk_reg(8'(g), 8'h0c);
        gap(g);
        chk_reg(8'(g), 8'h08);
        $display("standby test done");
    endtask : t_standby
    task automatic print_verdict();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    // Watchdog well beyond the few hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        print_verdict();
    end
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_limits();
        t_alert();
        t_ara();
        t_standby();
        print_verdict();
    end
endmodule : tb_temp_limit_status_monitor
